// File: hw/gdsc_top.sv
// serial register interface, sleep/wake and fault clearing of the gate driver
`timescale 1ns/1ps
`default_nettype none
`include "gdsc_map.svh"

module gdsc_top
   import gdsc_pkg::*;
#(
   parameter int SLEEP_NS = `GDSC_T_SLEEP_NS,
   parameter int WAKE_NS = `GDSC_T_WAKE_NS,
   parameter int RST_NS = `GDSC_T_RST_NS,
   parameter int RETRY_NS = `GDSC_T_RETRY_NS
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_enable,
   input wire logic i_vm_ok,
   input wire logic i_pwm,
   input wire logic [10:0] i_fault_evt_one,
   input wire logic [10:0] i_fault_evt_two,
   input wire logic i_sclk,
   input wire logic i_chip_select_n,
   input wire logic i_sdi,
   output logic o_sdo_out,
   output logic o_sdo_oe,
   output logic o_sleep,
   output logic o_operating,
   output logic o_gate_enable,
   output logic o_fault_n,
   output logic o_frame_error,
   output logic [10:0] o_driver_control,
   output logic [10:0] o_high_side_drive,
   output logic [10:0] o_overcurrent_control,
   output logic [10:0] o_current_amp_control,
   output logic [10:0] o_driver_configuration,
   output logic o_cycle_by_cycle_clear,
   output logic [1:0] o_overcurrent_response_mode,
   output logic [12:0] o_peak_drive_time_ns,
   output logic [9:0] o_low_side_source_ma,
   output logic [10:0] o_low_side_sink_ma
);

   // least times round up, the reset window is a longest time and rounds down
   localparam int SLEEP_CYC = (SLEEP_NS + `GDSC_CLK_NS - 1) / `GDSC_CLK_NS;
   localparam int WAKE_CYC = (WAKE_NS + `GDSC_CLK_NS - 1) / `GDSC_CLK_NS;
   localparam int RST_CYC = (RST_NS / `GDSC_CLK_NS < 1) ? 1 : RST_NS / `GDSC_CLK_NS;
   localparam int RETRY_CYC = (RETRY_NS + `GDSC_CLK_NS - 1) / `GDSC_CLK_NS;
   localparam logic [23:0] SLEEP_LAST = 24'(SLEEP_CYC - 1);
   localparam logic [23:0] WAKE_LAST = 24'(WAKE_CYC - 1);
   localparam logic [23:0] RST_LIM = 24'(RST_CYC);
   localparam logic [23:0] RETRY_LAST = 24'(RETRY_CYC - 1);

   // source current in mA per code; sink steps are exactly twice these
   localparam logic [15:0][9:0] SRC_MA = {
      10'h3E8, 10'h3B6, 10'h384, 10'h352, 10'h2BC, 10'h28A, 10'h258, 10'h226,
      10'h1C2, 10'h190, 10'h15E, 10'h12C, 10'h096, 10'h064, 10'h032, 10'h032};

   function automatic logic [7:0][10:0] reg_defaults();
      logic [7:0][10:0] d;
      d = '0;
      d[`GDSC_ADDR_HSD] = `GDSC_DEF_HSD;
      d[`GDSC_ADDR_LSD] = `GDSC_DEF_LSD;
      return d;
   endfunction

   gdsc_sys_t s_r;
   gdsc_sys_t s_nxt;

   // link side, clocked by the master's serial clock
   logic [15:0] lk_sh_r;
   logic [4:0] lk_cnt_r;
   logic lk_tog_r;
   logic lk_arm_r;
   logic lk_out_r;
   logic [9:0] lk_osh_r;
   logic [10:0] lk_word;

   // arm is forced while chip select is high so the first falling edge restarts the count
   always_ff @(negedge i_sclk or posedge i_chip_select_n) begin
      if (i_chip_select_n) begin
         lk_arm_r <= 1'b1;
      end else begin
         lk_arm_r <= 1'b0;
      end
   end

   // input shifter: sampled on falling clock, msb first; count saturates to mark long frames
   always_ff @(negedge i_sclk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         lk_sh_r <= 16'h0000;
         lk_cnt_r <= 5'h00;
         lk_tog_r <= 1'b0;
      end else if (!i_chip_select_n) begin
         if (lk_arm_r) begin
            lk_sh_r <= {15'h0000, i_sdi};
            lk_cnt_r <= 5'h01;
            lk_tog_r <= ~lk_tog_r;
         end else begin
            lk_sh_r <= {lk_sh_r[14:0], i_sdi};
            if (lk_cnt_r != `GDSC_FRAME_SAT) begin
               lk_cnt_r <= lk_cnt_r + 5'h01;
            end
         end
      end
   end

   // snapshot stays frozen while chip select is low, so reading it here is safe
   assign lk_word = lk_sh_r[3] ? 11'h000 : s_r.snap[lk_sh_r[2:0]];

   // output shifter: changes on rising clock; five released bits, then the register
   always_ff @(posedge i_sclk or posedge i_chip_select_n) begin
      if (i_chip_select_n) begin
         lk_out_r <= 1'b1;
         lk_osh_r <= 10'h3FF;
      end else if (!lk_arm_r && lk_cnt_r == `GDSC_CMD_BITS) begin
         {lk_out_r, lk_osh_r} <= lk_word;
      end else begin
         {lk_out_r, lk_osh_r} <= {lk_osh_r, 1'b1};
      end
   end

   // open drain: only ever pulls low, released while deselected or asleep
   assign o_sdo_out = 1'b0;
   assign o_sdo_oe = !i_chip_select_n && s_r.state == GDSC_RUN && !lk_out_r;

   logic frame_end;
   logic frame_ok;
   logic do_write;
   logic [3:0] waddr;
   logic [10:0] wdata;
   logic clr_cmd;
   logic pulse_clr;
   logic retry_done;
   logic cbc_clr;
   logic [10:0] clr_one;
   logic [10:0] clr_two;
   logic [10:0] fs_one;
   logic [10:0] fs_two;

   // system side: synchronisers, mode control, frame commit and fault latches
   always_comb begin
      s_nxt = s_r;
      frame_end = 1'b0;
      frame_ok = 1'b0;
      do_write = 1'b0;
      waddr = lk_sh_r[`GDSC_ADDR_HI:`GDSC_ADDR_LO];
      wdata = lk_sh_r[10:0];
      clr_cmd = 1'b0;
      pulse_clr = 1'b0;
      retry_done = 1'b0;
      cbc_clr = 1'b0;
      clr_one = 11'h000;
      clr_two = 11'h000;
      fs_one = 11'h000;
      fs_two = 11'h000;
      s_nxt.en_s1 = i_enable;
      s_nxt.en_s2 = s_r.en_s1;
      s_nxt.vm_s1 = i_vm_ok;
      s_nxt.vm_s2 = s_r.vm_s1;
      s_nxt.pwm_s1 = i_pwm;
      s_nxt.pwm_s2 = s_r.pwm_s1;
      s_nxt.pwm_s3 = s_r.pwm_s2;
      s_nxt.cs_s1 = i_chip_select_n;
      s_nxt.cs_s2 = s_r.cs_s1;
      s_nxt.cs_s3 = s_r.cs_s2;
      s_nxt.tog_s1 = lk_tog_r;
      s_nxt.tog_s2 = s_r.tog_s1;
      s_nxt.frame_err = 1'b0;
      // frame ends when synced chip select rises; link data is static by then
      frame_end = s_r.cs_s2 && !s_r.cs_s3;
      if (frame_end) begin
         s_nxt.tog_seen = s_r.tog_s2;
         frame_ok = s_r.tog_s2 != s_r.tog_seen && lk_cnt_r == `GDSC_FRAME_BITS;
         if (s_r.state == GDSC_RUN) begin
            s_nxt.frame_err = !frame_ok;
            do_write = frame_ok && !lk_sh_r[`GDSC_RW_BIT];
         end
      end
      // status registers are never written from the link
      if (do_write && waddr >= `GDSC_ADDR_DRV && waddr <= `GDSC_ADDR_CFG) begin
         s_nxt.regs[waddr[2:0]] = wdata;
         if (waddr == `GDSC_ADDR_DRV) begin
            clr_cmd = wdata[`GDSC_CLEAR_FAULT_BIT_BIT];
            s_nxt.regs[waddr[2:0]][`GDSC_CLEAR_FAULT_BIT_BIT] = 1'b0;
         end
      end
      // enable sequencing
      unique case (s_r.state)
         GDSC_SLEEP: begin
            s_nxt.cnt = 24'h000000;
            if (s_r.en_s2) begin
               s_nxt.state = GDSC_WAKE;
            end
         end
         GDSC_WAKE: begin
            s_nxt.cnt = s_r.cnt + 24'h000001;
            if (!s_r.en_s2) begin
               s_nxt.state = GDSC_ENLOW;
               s_nxt.cnt = 24'h000000;
            end else if (s_r.cnt == WAKE_LAST) begin
               s_nxt.state = GDSC_RUN;
            end
         end
         GDSC_RUN: begin
            if (!s_r.en_s2) begin
               s_nxt.state = GDSC_ENLOW;
               s_nxt.cnt = 24'h000000;
            end
         end
         GDSC_ENLOW: begin
            s_nxt.cnt = s_r.cnt + 24'h000001;
            if (s_r.cnt == SLEEP_LAST) begin
               s_nxt.state = GDSC_SLEEP;
            end else if (s_r.en_s2 && s_r.cnt < RST_LIM) begin
               s_nxt.state = GDSC_RUN;
               pulse_clr = 1'b1;
            end
         end
      endcase
      // retry timer runs only while retry-mode overcurrent is latched
      if (s_r.regs[`GDSC_ADDR_OCP][`GDSC_MODE_HI:`GDSC_MODE_LO] == `GDSC_MODE_RETRY &&
          |(s_r.regs[`GDSC_ADDR_FS1] & `GDSC_FS1_OC_MASK)) begin
         s_nxt.retry_cnt = s_r.retry_cnt + 24'h000001;
         if (s_r.retry_cnt == RETRY_LAST) begin
            retry_done = 1'b1;
            s_nxt.retry_cnt = 24'h000000;
         end
         cbc_clr = s_r.regs[`GDSC_ADDR_LSD][`GDSC_CBC_BIT] && s_r.pwm_s2 && !s_r.pwm_s3;
      end else begin
         s_nxt.retry_cnt = 24'h000000;
      end
      // a clear never beats an event in the same cycle; live conditions re-set their bit
      if (clr_cmd || pulse_clr) begin
         clr_one = 11'h7FF;
         clr_two = 11'h7FF;
      end else if (retry_done || cbc_clr) begin
         clr_one = `GDSC_FS1_OC_MASK;
      end
      fs_one = (s_r.regs[`GDSC_ADDR_FS1] & ~clr_one) | i_fault_evt_one;
      fs_two = (s_r.regs[`GDSC_ADDR_FS2] & ~clr_two) | i_fault_evt_two;
      fs_one[`GDSC_FAULT_BIT] = |{fs_one[9:0], fs_two};
      s_nxt.regs[`GDSC_ADDR_FS1] = fs_one;
      s_nxt.regs[`GDSC_ADDR_FS2] = fs_two;
      // asleep or leaving for sleep: registers and retry timer back to defaults
      if (s_r.state == GDSC_SLEEP || s_nxt.state == GDSC_SLEEP) begin
         s_nxt.regs = reg_defaults();
         s_nxt.retry_cnt = 24'h000000;
      end
      // snapshot tracks the registers only while deselected
      if (s_r.cs_s2) begin
         s_nxt.snap = s_r.regs;
      end
      if (i_sys_rst) begin
         s_nxt = '0;
         s_nxt.state = GDSC_SLEEP;
         s_nxt.regs = reg_defaults();
         s_nxt.snap = reg_defaults();
         s_nxt.cs_s1 = 1'b1;
         s_nxt.cs_s2 = 1'b1;
         s_nxt.cs_s3 = 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      s_r <= s_nxt;
   end

   // mode outputs
   assign o_sleep = s_r.state == GDSC_SLEEP;
   assign o_operating = s_r.state == GDSC_RUN && s_r.vm_s2;
   assign o_gate_enable = o_operating && !s_r.regs[`GDSC_ADDR_FS1][`GDSC_FAULT_BIT];
   assign o_fault_n = !s_r.regs[`GDSC_ADDR_FS1][`GDSC_FAULT_BIT];
   assign o_frame_error = s_r.frame_err;

   // control register fields
   assign o_driver_control = s_r.regs[`GDSC_ADDR_DRV];
   assign o_high_side_drive = s_r.regs[`GDSC_ADDR_HSD];
   assign o_overcurrent_control = s_r.regs[`GDSC_ADDR_OCP];
   assign o_current_amp_control = s_r.regs[`GDSC_ADDR_CSA];
   assign o_driver_configuration = s_r.regs[`GDSC_ADDR_CFG];
   assign o_cycle_by_cycle_clear = s_r.regs[`GDSC_ADDR_LSD][`GDSC_CBC_BIT];
   assign o_overcurrent_response_mode = s_r.regs[`GDSC_ADDR_OCP][`GDSC_MODE_HI:`GDSC_MODE_LO];
   assign o_peak_drive_time_ns = `GDSC_PEAK_DRIVE_TIME_BASE_NS << s_r.regs[`GDSC_ADDR_LSD][`GDSC_PEAK_DRIVE_TIME_HI:`GDSC_PEAK_DRIVE_TIME_LO];
   assign o_low_side_source_ma = SRC_MA[s_r.regs[`GDSC_ADDR_LSD][`GDSC_SRC_HI:`GDSC_SRC_LO]];
   assign o_low_side_sink_ma = {SRC_MA[s_r.regs[`GDSC_ADDR_LSD][`GDSC_SNK_HI:`GDSC_SNK_LO]], 1'b0};

   // checks, all in the system clock domain
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   sequence s_short_low;
      s_r.state == GDSC_ENLOW && s_r.en_s2 && s_r.cnt < RST_LIM && s_r.cnt != SLEEP_LAST;
   endsequence

   sequence s_valid_write(int a);
      frame_end && frame_ok && s_r.state == GDSC_RUN && !lk_sh_r[`GDSC_RW_BIT] && waddr == 4'(a);
   endsequence

   chk_sleep_quiet: assert property (o_sleep |-> !o_operating && !o_gate_enable && !o_sdo_oe)
      else $error("outputs active while asleep");
   chk_sleep_defaults: assert property ($rose(o_sleep) |-> o_high_side_drive == `GDSC_DEF_HSD
      && s_r.regs[`GDSC_ADDR_LSD] == `GDSC_DEF_LSD && o_overcurrent_control == `GDSC_DEF_ZERO)
      else $error("registers not at default on sleep entry");
   chk_sleep_delay: assert property ($rose(o_sleep) |-> $past(s_r.state) == GDSC_ENLOW
      && $past(s_r.cnt) == SLEEP_LAST)
      else $error("sleep entered before the delay");
   chk_wake_exit: assert property (o_sleep && s_r.en_s2 |=> s_r.state == GDSC_WAKE ##1 !o_sleep)
      else $error("enable high did not leave sleep");
   chk_pulse_keeps: assert property (s_short_low |=> s_r.state == GDSC_RUN && $stable(o_high_side_drive)
      && $stable(o_overcurrent_control) && $stable(o_driver_configuration))
      else $error("reset pulse changed settings");
   chk_bad_frame: assert property (frame_end && !frame_ok && s_r.state == GDSC_RUN
      |=> o_frame_error && $stable(o_high_side_drive) ##1 !o_frame_error)
      else $error("bad frame not flagged or not discarded");
   chk_write_commit: assert property (s_valid_write(`GDSC_ADDR_HSD) |=> o_high_side_drive == $past(wdata))
      else $error("valid write not committed");
   chk_retry_clear: assert property (retry_done && i_fault_evt_one == 11'h000 && !o_sleep
      |=> (s_r.regs[`GDSC_ADDR_FS1] & `GDSC_FS1_OC_MASK) == 11'h000)
      else $error("overcurrent bits not cleared at retry end");
   chk_drive_time: assert property (o_peak_drive_time_ns >= 13'h01F4 && o_peak_drive_time_ns <= 13'h0FA0)
      else $error("drive time out of range");

   // deselected link must leave the shared open-drain line alone
   chk_sdo_released: assert property (i_chip_select_n |-> !o_sdo_oe)
      else $error("serial output driven while deselected");

   // a latched fault keeps the gates off whatever the mode
   chk_fault_gates: assert property (!o_fault_n |-> !o_gate_enable)
      else $error("gates enabled with a latched fault");

   // a write aimed at a status register may not set any of its bits
   chk_status_ro: assert property (s_valid_write(`GDSC_ADDR_FS2) ##0 i_fault_evt_two == 11'h000
      |=> (s_r.regs[`GDSC_ADDR_FS2] & ~$past(s_r.regs[`GDSC_ADDR_FS2])) == 11'h000)
      else $error("status register took link data");

   // frames outside the operating state are ignored, not flagged
   chk_idle_no_error: assert property (s_r.state != GDSC_RUN |=> !o_frame_error)
      else $error("frame error outside operating state");

   // supply below threshold never counts as operating
   chk_supply_low: assert property (!s_r.vm_s2 |-> !o_operating)
      else $error("operating with supply low");

endmodule
`default_nettype wire

// File: hw/gdsc_map.svh
// register map, field positions, reset values and timing figures of the gate driver serial control
`ifndef GDSC_MAP_SVH
`define GDSC_MAP_SVH

`define GDSC_ADDR_FS1 4'h0
`define GDSC_ADDR_FS2 4'h1
`define GDSC_ADDR_DRV 4'h2
`define GDSC_ADDR_HSD 4'h3
`define GDSC_ADDR_LSD 4'h4
`define GDSC_ADDR_OCP 4'h5
`define GDSC_ADDR_CSA 4'h6
`define GDSC_ADDR_CFG 4'h7

`define GDSC_DEF_ZERO 11'h000
`define GDSC_DEF_HSD 11'h3FF
`define GDSC_DEF_LSD 11'h7FF

`define GDSC_FRAME_BITS 5'h10
`define GDSC_FRAME_SAT 5'h11
`define GDSC_CMD_BITS 5'h05
`define GDSC_RW_BIT 15
`define GDSC_ADDR_HI 14
`define GDSC_ADDR_LO 11

`define GDSC_FAULT_BIT 10
`define GDSC_CLEAR_FAULT_BIT_BIT 0
`define GDSC_CBC_BIT 10
`define GDSC_PEAK_DRIVE_TIME_HI 9
`define GDSC_PEAK_DRIVE_TIME_LO 8
`define GDSC_SRC_HI 7
`define GDSC_SRC_LO 4
`define GDSC_SNK_HI 3
`define GDSC_SNK_LO 0
`define GDSC_MODE_HI 7
`define GDSC_MODE_LO 6
`define GDSC_MODE_RETRY 2'h1
`define GDSC_FS1_OC_MASK 11'h300
`define GDSC_PEAK_DRIVE_TIME_BASE_NS 13'h01F4

`define GDSC_CLK_NS 5
`define GDSC_T_SLEEP_NS 100000
`define GDSC_T_WAKE_NS 1000000
`define GDSC_T_RST_NS 20000
`define GDSC_T_RETRY_NS 4000000

`endif

// File: hw/gdsc_pkg.sv
// types of the gate driver serial control block
package gdsc_pkg;

   typedef enum logic [1:0] {
      GDSC_SLEEP = 2'b00,
      GDSC_WAKE = 2'b01,
      GDSC_RUN = 2'b10,
      GDSC_ENLOW = 2'b11
   } gdsc_state_t;

   typedef struct packed {
      gdsc_state_t state;
      logic [23:0] cnt;
      logic [23:0] retry_cnt;
      logic [7:0][10:0] regs;
      logic [7:0][10:0] snap;
      logic en_s1;
      logic en_s2;
      logic vm_s1;
      logic vm_s2;
      logic pwm_s1;
      logic pwm_s2;
      logic pwm_s3;
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic tog_s1;
      logic tog_s2;
      logic tog_seen;
      logic frame_err;
   } gdsc_sys_t;

endpackage

// File: testbench/gdsc_spi_master.sv
// serial master model that drives frames into the gate driver link
`timescale 1ns/1ps
`default_nettype none
module gdsc_spi_master (
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_sdi,
   input wire logic i_sdo
);
   // link rests with clock low and select high; clock only runs inside frames
   initial begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi = 1'b0;
   end

   // sends nbits of w msb first; counts other than 16 provoke frame errors
   task automatic xfer(input logic [16:0] w, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      o_cs_n = 1'b0;
      #16;
      for (int i = nbits - 1; i >= 0; i--) begin
         o_sclk = 1'b1;
         o_sdi = w[i];
         #16;
         o_sclk = 1'b0;
         rx = {rx[14:0], i_sdo};
         #16;
      end
      o_cs_n = 1'b1;
      // released data line must not keep the last bit
      o_sdi = ~o_sdi;
      #500;
   endtask
endmodule
`default_nettype wire

// File: testbench/gdsc_tb_top.sv
// self-checking bench of the gate driver serial control
`timescale 1ns/1ps
`default_nettype none
`include "gdsc_map.svh"
module gdsc_tb_top;
   logic i_clk, i_sys_rst, i_enable, i_vm_ok, i_pwm, sclk, cs_n, sdi;
   logic [10:0] fe1, fe2, hsd, snk, drv_o, ocp_o, csa_o, cfg_o;
   logic [1:0] mode_o;
   logic sdo_out, sdo_oe, slp, op, gate, fault_n, ferr_p, cbc;
   logic [12:0] tdrv;
   logic [9:0] src;
   wire sdo_w;
   int comparisons, miscompares, ferr;
   logic [10:0] def [8];
   logic [10:0] mirror [8];

   // open-drain output with pull-up on the board side
   assign sdo_w = sdo_oe ? sdo_out : 1'b1;

   always #2.5 i_clk = ~i_clk;

   // error strobe lasts one cycle, so count it where it happens
   always @(posedge i_clk) begin
      if (ferr_p === 1'b1) begin
         ferr++;
      end
   end

   // short timing parameters keep the run brief
   gdsc_top #(.SLEEP_NS(500), .WAKE_NS(200), .RST_NS(100), .RETRY_NS(300)) u_dut (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_enable(i_enable), .i_vm_ok(i_vm_ok),
      .i_pwm(i_pwm), .i_fault_evt_one(fe1), .i_fault_evt_two(fe2), .i_sclk(sclk),
      .i_chip_select_n(cs_n), .i_sdi(sdi), .o_sdo_out(sdo_out), .o_sdo_oe(sdo_oe),
      .o_sleep(slp), .o_operating(op), .o_gate_enable(gate), .o_fault_n(fault_n),
      .o_frame_error(ferr_p), .o_driver_control(drv_o), .o_high_side_drive(hsd),
      .o_overcurrent_control(ocp_o), .o_current_amp_control(csa_o), .o_driver_configuration(cfg_o),
      .o_cycle_by_cycle_clear(cbc), .o_overcurrent_response_mode(mode_o), .o_peak_drive_time_ns(tdrv),
      .o_low_side_source_ma(src), .o_low_side_sink_ma(snk));

   gdsc_spi_master u_m (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo_w));

   // source current in mA for a 4-bit code; sink is twice this
   function automatic logic [10:0] src_ma(input logic [3:0] c);
      logic [10:0] t [16] = '{11'h032, 11'h032, 11'h064, 11'h096, 11'h12C, 11'h15E, 11'h190, 11'h1C2,
                              11'h226, 11'h258, 11'h28A, 11'h2BC, 11'h352, 11'h384, 11'h3B6, 11'h3E8};
      return t[c];
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic frame(input logic rw, input logic [3:0] a, input logic [10:0] d, output logic [10:0] q);
      logic [15:0] rx;
      u_m.xfer({1'b0, rw, a, d}, 16, rx);
      q = rx[10:0];
      tick(2);
   endtask

   // bounded wait for the operating state after enable rises
   task automatic wait_run();
      int n;
      n = 0;
      while (op !== 1'b1 && n < 3000) begin
         tick(1);
         n++;
      end
      chk(op, 1, "wake");
   endtask

   // reads every address, random data bits must be ignored on reads
   task automatic check_map();
      logic [10:0] q;
      for (int a = 0; a < 16; a++) begin
         frame(1'b1, a[3:0], 11'($urandom), q);
         chk(q, (a < 8) ? mirror[a] : 11'h000, "read map");
      end
      chk(sdo_oe, 0, "released");
      chk(drv_o, mirror[2], "drv port");
      chk(ocp_o, mirror[5], "ocp port");
      chk(csa_o, mirror[6], "csa port");
      chk(cfg_o, mirror[7], "cfg port");
   endtask

   task automatic done(input string t);
      $display("test %s done", t);
   endtask

   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #400000;
      miscompares++;
      results();
   end

   initial begin
      logic [10:0] q, v;
      logic [3:0] a;
      int f0, k;
      i_clk = 1'b0;
      i_sys_rst = 1'b1;
      i_enable = 1'b0;
      i_vm_ok = 1'b1;
      i_pwm = 1'b0;
      fe1 = 11'h000;
      fe2 = 11'h000;
      def = '{`GDSC_DEF_ZERO, `GDSC_DEF_ZERO, `GDSC_DEF_ZERO, `GDSC_DEF_HSD, `GDSC_DEF_LSD,
              `GDSC_DEF_ZERO, `GDSC_DEF_ZERO, `GDSC_DEF_ZERO};
      mirror = def;
      void'($urandom(32'hA6AB1248));
      tick(20);
      i_sys_rst = 1'b0;
      tick(2);
      chk(slp, 1, "sleep at reset");
      i_enable = 1'b1;
      wait_run();
      check_map();
      done("defaults");
      // random writes answer with the old contents; status writes are dropped
      for (int i = 0; i < 14; i++) begin
         a = (i % 5 == 4) ? 4'(i % 2) : 4'(2 + $urandom % 6);
         v = 11'($urandom);
         if (a == `GDSC_ADDR_DRV) v[`GDSC_CLEAR_FAULT_BIT_BIT] = 1'b0;
         frame(1'b0, a, v, q);
         chk(q, mirror[a], "write echo");
         if (a > 4'h1) mirror[a] = v;
      end
      chk(hsd, mirror[3], "hs port");
      // every drive time code with random current codes
      for (int t = 0; t < 4; t++) begin
         v = {1'($urandom), 2'(t), 8'($urandom)};
         frame(1'b0, `GDSC_ADDR_LSD, v, q);
         mirror[4] = v;
         chk(tdrv, 13'h01F4 << t, "drive time");
         chk(src, src_ma(v[7:4]), "source");
         chk(snk, src_ma(v[3:0]) << 1, "sink");
         chk(cbc, v[10], "cbc bit");
      end
      check_map();
      done("writes");
      // short, long and empty frames are all discarded
      f0 = ferr;
      u_m.xfer({2'b00, `GDSC_ADDR_HSD, 11'h0AA}, 15, {q, a, v[0]});
      u_m.xfer({2'b00, `GDSC_ADDR_HSD, 11'h155}, 17, {q, a, v[0]});
      u_m.xfer(17'h00000, 0, {q, a, v[0]});
      tick(10);
      chk(ferr - f0, 3, "frame errors");
      check_map();
      done("frame errors");
      // latched fault cleared by a short enable pulse, settings kept
      k = $urandom % 11;
      fe2[k] = 1'b1;
      tick(1);
      fe2 = 11'h000;
      tick(6);
      chk(fault_n, 0, "fault latched");
      chk(gate, 0, "gates off");
      frame(1'b1, `GDSC_ADDR_FS2, 11'h000, q);
      chk(q, 11'h001 << k, "status two");
      i_enable = 1'b0;
      tick(10);
      i_enable = 1'b1;
      tick(10);
      chk(fault_n, 1, "pulse clears");
      chk(op, 1, "still operating");
      check_map();
      // same fault cleared by the clear bit, which reads back as zero
      fe2[k] = 1'b1;
      tick(1);
      fe2 = 11'h000;
      frame(1'b0, `GDSC_ADDR_DRV, mirror[2] | 11'h001, q);
      tick(8);
      chk(fault_n, 1, "bit clears");
      check_map();
      done("fault clear");
      // retry mode: overcurrent held until retry time, or a pwm edge with cbc
      frame(1'b0, `GDSC_ADDR_OCP, 11'h040, q);
      mirror[5] = 11'h040;
      mirror[4] = mirror[4] & 11'h3FF;
      frame(1'b0, `GDSC_ADDR_LSD, mirror[4], q);
      chk(mode_o, 2'h1, "retry mode");
      fe1[9] = 1'b1;
      tick(1);
      fe1 = 11'h000;
      tick(35);
      chk(fault_n, 0, "retry hold");
      tick(50);
      chk(fault_n, 1, "retry done");
      check_map();
      mirror[4] = mirror[4] | 11'h400;
      frame(1'b0, `GDSC_ADDR_LSD, mirror[4], q);
      fe1[8] = 1'b1;
      tick(1);
      fe1 = 11'h000;
      tick(5);
      chk(fault_n, 0, "cbc hold");
      i_pwm = 1'b1;
      tick(8);
      chk(fault_n, 1, "cbc pwm clears");
      i_pwm = 1'b0;
      done("retry");
      // supply loss leaves operating; long enable low sleeps and resets
      i_vm_ok = 1'b0;
      tick(6);
      chk(op, 0, "supply low");
      i_vm_ok = 1'b1;
      tick(6);
      i_enable = 1'b0;
      tick(60);
      chk(slp, 0, "sleep delay");
      tick(100);
      chk(slp, 1, "asleep");
      chk(hsd, `GDSC_DEF_HSD, "hs default");
      i_enable = 1'b1;
      mirror = def;
      wait_run();
      check_map();
      done("sleep");
      results();
   end
endmodule
`default_nettype wire
